/* File: bench/sscf_card_model.sv */
// card in socket: insertion level and dma request line
`timescale 1ns/1ps
module sscf_card_model (
    // bench controls
    input wire logic clock,
    input wire logic insert,
    input wire logic card_dma_request,
    // socket pins
    output logic cardBusInserted = 1'b0,
    output logic cardDmaRequest = 1'b0
);
    // a card only requests dma while it sits in the socket
    always @(negedge clock) begin
        cardBusInserted <= insert;
        cardDmaRequest <= card_dma_request & insert;
    end
endmodule : sscf_card_model

/* File: bench/sscf_socket_system_control_fields_test.sv */
// self-checking bench for the system control fields
`timescale 1ns/1ps
module sscf_socket_system_control_fields_test;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    sscf_pkg::sscf_cfg_req_t cfgReq = '0;
    logic sockPowerWrite = 1'b0;
    logic insert = 1'b0;
    logic card_dma_request = 1'b0;
    logic cardBusInserted, cardDmaRequest, pwrMgmtIrq, legacyIrqLineTwo, cardStatusChangeIrq;
    logic addrHighFloat, cardDmaReqOut;
    logic [31:0] cfgRdData;
    logic [3:0] rsvdTermOut, rsvdTermOe;
    sscf_pkg::sscf_ctrl_t ctrl;
    int mismatches = 0;
    int n_compared = 0;
    always #10 clock = ~clock;
    sscf_socket_system_control_fields i_sscf_socket_system_control_fields (.clock(clock), .nrst(nrst),
        .cfgReq(cfgReq), .cfgRdData(cfgRdData), .sockPowerWrite(sockPowerWrite), .cardBusInserted(cardBusInserted),
        .cardDmaRequest(cardDmaRequest), .pwrMgmtIrq(pwrMgmtIrq), .legacyIrqLineTwo(legacyIrqLineTwo),
        .cardStatusChangeIrq(cardStatusChangeIrq), .rsvdTermOut(rsvdTermOut), .rsvdTermOe(rsvdTermOe),
        .addrHighFloat(addrHighFloat), .cardDmaReqOut(cardDmaReqOut), .ctrl(ctrl));
    sscf_card_model i_sscf_card_model (.clock(clock), .insert(insert), .card_dma_request(card_dma_request),
        .cardBusInserted(cardBusInserted), .cardDmaRequest(cardDmaRequest));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfgReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, byteEn: 4'hf, wrData: d};
        @(negedge clock);
        cfgReq.wrEn = 1'b0;
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cfgReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, byteEn: 4'hf, wrData: 32'h0};
        @(negedge clock);
        cfgReq.rdEn = 1'b0;
        cmp("read", exp, cfgRdData);
        @(negedge clock);
    endtask : rd
    task automatic pw();
        sockPowerWrite = 1'b1;
        @(negedge clock);
        sockPowerWrite = 1'b0;
    endtask : pw
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(20 * 5000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        rd(8'h80, sscf_pkg::SYS_CTRL_RESET & sscf_pkg::FIELD_MASK);
        rd(8'h84, 32'h0);
        cmp("burst", 32'h1, 32'(ctrl.burstDownAllowed));
        cmp("protect", 32'h1, 32'(ctrl.supplyProtectOn));
        wr(8'h80, 32'h0100_0000);
        pw();
        cmp("irq", 32'h1, 32'(pwrMgmtIrq));
        cmp("line two", 32'h1, 32'(legacyIrqLineTwo));
        @(negedge clock);
        cmp("pulse", 32'h0, 32'(pwrMgmtIrq));
        rd(8'h80, 32'h0300_0000);
        wr(8'h80, 32'h0500_0000);
        pw();
        cmp("status change", 32'h1, 32'(cardStatusChangeIrq));
        cmp("line two", 32'h0, 32'(legacyIrqLineTwo));
        wr(8'h80, 32'h0);
        rd(8'h80, 32'h0200_0000);
        wr(8'h80, 32'h0200_0000);
        pw();
        cmp("masked", 32'h0, 32'(pwrMgmtIrq));
        rd(8'h80, 32'h0);
        insert = 1'b1;
        card_dma_request = 1'b1;
        repeat (2) @(negedge clock);
        cmp("rsvd oe", 32'h0, 32'(rsvdTermOe));
        cmp("dma gated", 32'h0, 32'(cardDmaReqOut));
        wr(8'h80, 32'h0040_0000);
        cmp("rsvd oe", 32'hf, 32'(rsvdTermOe));
        cmp("rsvd out", 32'h0, 32'(rsvdTermOut));
        for (int ch = 0; ch < 8; ch++) begin
            wr(8'h80, 32'h00b8_0000 | (32'(ch) << 16));
            cmp("chan16", 32'(ch > 4), 32'(ctrl.dmaChannel16));
            cmp("unused", 32'(ch == 4), 32'(ctrl.dmaUnused));
            cmp("chan", 32'(ch), 32'(ctrl.dmaChannel));
        end
        cmp("float", 32'h1, 32'(addrHighFloat));
        cmp("rev", 32'h1, 32'(ctrl.pmRev11));
        cmp("protect", 32'h0, 32'(ctrl.supplyProtectOn));
        cmp("dma req", 32'h1, 32'(cardDmaReqOut));
        cmp("dma allowed", 32'h1, 32'(ctrl.dmaReqAllowed));
        cmp("burst", 32'h0, 32'(ctrl.burstDownAllowed));
        tally_and_finish();
    end
endmodule : sscf_socket_system_control_fields_test

/* File: core/sscf_pkg.sv */
// package: offset, field positions, reset value and carriers for the system control fields
package sscf_pkg;
    localparam logic [7:0] SYS_CTRL_OFFSET = 8'h80;
    localparam logic [31:0] SYS_CTRL_RESET = 32'h0044_9060;
    localparam int PWR_IRQ_ROUTE_SEL_BIT = 26;
    localparam int PWR_IRQ_FLAG_BIT = 25;
    localparam int PWR_IRQ_MODE_EN_BIT = 24;
    localparam int PM_REV_SEL_BIT = 23;
    localparam int RSVD_TERM_DRIVE_LOW_BIT = 22;
    localparam int SUPPLY_PROTECT_DIS_BIT = 21;
    localparam int VIDEO_PORT_REDUCE_EN_BIT = 20;
    localparam int CARD_DMA_REQ_EN_BIT = 19;
    localparam int CARD_DMA_CHANNEL_LSB = 16;
    localparam int DOWNSTREAM_READ_BURST_EN_BIT = 15;
    localparam logic [31:0] FIELD_MASK = 32'h07ff_8000;
    localparam logic [2:0] DMA_CHAN_HOST_MASTER = 3'h4;

    // configuration access request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } sscf_cfg_req_t;

    // decoded controls steering neighbouring engines
    typedef struct packed {
        logic pmRev11;
        logic supplyProtectOn;
        logic dmaReqAllowed;
        logic dmaChannel16;
        logic [2:0] dmaChannel;
        logic dmaUnused;
        logic burstDownAllowed;
    } sscf_ctrl_t;
endpackage : sscf_pkg

/* File: core/sscf_socket_system_control_fields.sv */
// socket system control register, bits 26 down to 15
`timescale 1ns/1ps

module sscf_socket_system_control_fields (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration access
    input wire sscf_pkg::sscf_cfg_req_t cfgReq,
    output logic [31:0] cfgRdData,
    // socket events
    input wire logic sockPowerWrite,
    input wire logic cardBusInserted,
    input wire logic cardDmaRequest,
    // interrupt outputs
    output logic pwrMgmtIrq,
    output logic legacyIrqLineTwo,
    output logic cardStatusChangeIrq,
    // card pin controls
    output logic [3:0] rsvdTermOut,
    output logic [3:0] rsvdTermOe,
    output logic addrHighFloat,
    output logic cardDmaReqOut,
    // decoded controls
    output sscf_pkg::sscf_ctrl_t ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    logic rstMeta_q;
    logic rstSync_q;
    logic rstN;
    logic [31:0] reg_q;
    logic [31:0] reg_d;
    logic [31:0] byteMask;
    logic hit;
    logic irqPulse_q;
    logic pwrWriteEn;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rstN = rstSync_q;

    ////////////////////////////////////////////////////////////////////////////
    // register write path
    assign hit = cfgReq.addr == sscf_pkg::SYS_CTRL_OFFSET;
    assign byteMask = lane_mask(cfgReq.byteEn) & sscf_pkg::FIELD_MASK;
    assign pwrWriteEn = sockPowerWrite & reg_q[sscf_pkg::PWR_IRQ_MODE_EN_BIT];

    always_comb begin
        reg_d = reg_q;
        if (cfgReq.wrEn && hit) begin
            reg_d = (reg_q & ~byteMask) | (cfgReq.wrData & byteMask);
            reg_d[sscf_pkg::PWR_IRQ_FLAG_BIT] = reg_q[sscf_pkg::PWR_IRQ_FLAG_BIT]
                & ~(byteMask[sscf_pkg::PWR_IRQ_FLAG_BIT] & cfgReq.wrData[sscf_pkg::PWR_IRQ_FLAG_BIT]);
        end
        if (sockPowerWrite && reg_q[sscf_pkg::PWR_IRQ_MODE_EN_BIT]) begin
            reg_d[sscf_pkg::PWR_IRQ_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            reg_q <= sscf_pkg::SYS_CTRL_RESET & sscf_pkg::FIELD_MASK;
        end else begin
            reg_q <= reg_d;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            cfgRdData <= 32'h0000_0000;
        end else if (cfgReq.rdEn && hit) begin
            cfgRdData <= reg_q;
        end else begin
            cfgRdData <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-change interrupt
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            irqPulse_q <= 1'b0;
        end else begin
            irqPulse_q <= sockPowerWrite & reg_q[sscf_pkg::PWR_IRQ_MODE_EN_BIT];
        end
    end
    assign pwrMgmtIrq = irqPulse_q;
    assign legacyIrqLineTwo = irqPulse_q & ~reg_q[sscf_pkg::PWR_IRQ_ROUTE_SEL_BIT];
    assign cardStatusChangeIrq = irqPulse_q & reg_q[sscf_pkg::PWR_IRQ_ROUTE_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // pins and decoded controls
    assign rsvdTermOut = 4'h0;
    assign rsvdTermOe = {4{cardBusInserted & reg_q[sscf_pkg::RSVD_TERM_DRIVE_LOW_BIT]}};
    assign addrHighFloat = reg_q[sscf_pkg::VIDEO_PORT_REDUCE_EN_BIT];
    assign cardDmaReqOut = cardDmaRequest & reg_q[sscf_pkg::CARD_DMA_REQ_EN_BIT];
    assign ctrl.pmRev11 = reg_q[sscf_pkg::PM_REV_SEL_BIT];
    assign ctrl.supplyProtectOn = ~reg_q[sscf_pkg::SUPPLY_PROTECT_DIS_BIT];
    assign ctrl.dmaReqAllowed = reg_q[sscf_pkg::CARD_DMA_REQ_EN_BIT];
    assign ctrl.dmaChannel = reg_q[sscf_pkg::CARD_DMA_CHANNEL_LSB +: 3];
    assign ctrl.dmaChannel16 = reg_q[sscf_pkg::CARD_DMA_CHANNEL_LSB + 2]
        & (reg_q[sscf_pkg::CARD_DMA_CHANNEL_LSB +: 3] != sscf_pkg::DMA_CHAN_HOST_MASTER);
    assign ctrl.dmaUnused = reg_q[sscf_pkg::CARD_DMA_CHANNEL_LSB +: 3] == sscf_pkg::DMA_CHAN_HOST_MASTER;
    assign ctrl.burstDownAllowed = reg_q[sscf_pkg::DOWNSTREAM_READ_BURST_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_powerWriteEnabled;
        sockPowerWrite && reg_q[sscf_pkg::PWR_IRQ_MODE_EN_BIT];
    endsequence

    sequence s_clearWrite;
        cfgReq.wrEn && hit && byteMask[25] && cfgReq.wrData[25];
    endsequence

    chk_flag_set_event: assert property (@(posedge clock) disable iff (!rstN)
        s_powerWriteEnabled |=> reg_q[sscf_pkg::PWR_IRQ_FLAG_BIT])
        else $error("flag not set after enabled power write");
    chk_flag_clear_one: assert property (@(posedge clock) disable iff (!rstN)
        s_clearWrite ##0 !pwrWriteEn |=> !reg_q[25])
        else $error("flag not cleared by write one");
    chk_flag_zero_keep: assert property (@(posedge clock) disable iff (!rstN)
        (reg_q[25] && !(cfgReq.wrEn && hit && byteMask[25] && cfgReq.wrData[25])) |=> reg_q[25])
        else $error("flag lost without write one");
    chk_irq_pulse: assert property (@(posedge clock) disable iff (!rstN)
        s_powerWriteEnabled |=> pwrMgmtIrq)
        else $error("no management irq after power write");
    chk_irq_route: assert property (@(posedge clock) disable iff (!rstN)
        pwrMgmtIrq |-> (legacyIrqLineTwo != cardStatusChangeIrq) && (cardStatusChangeIrq == reg_q[26]))
        else $error("irq routed to wrong line");
    chk_rsvd_drive: assert property (@(posedge clock) disable iff (!rstN)
        (rsvdTermOe != 4'h0) == (cardBusInserted && reg_q[22]))
        else $error("reserved terminal drive mismatch");
    chk_dma_gate: assert property (@(posedge clock) disable iff (!rstN)
        !reg_q[19] |-> !cardDmaReqOut)
        else $error("dma request passed while disabled");
    chk_dma_width: assert property (@(posedge clock) disable iff (!rstN)
        ctrl.dmaChannel16 |-> (ctrl.dmaChannel > 3'h4))
        else $error("dma channel width decode wrong");
    chk_reset_value: assert property (@(posedge clock) $rose(rstN) |-> reg_q == 32'h0044_8000)
        else $error("register reset value wrong");
    chk_float_pins: assert property (@(posedge clock) disable iff (!rstN)
        addrHighFloat == reg_q[20])
        else $error("address float mismatch");

    ////////////////////////////////////////////////////////////////////////////
    // further checks on bus, decode and pins
    chk_read_data: assert property (@(posedge clock) disable iff (!rstN)
        (cfgReq.rdEn && hit) |=> cfgRdData == $past(reg_q))
        else $error("read data wrong");
    chk_read_idle: assert property (@(posedge clock) disable iff (!rstN)
        !(cfgReq.rdEn && hit) |=> cfgRdData == 32'h0000_0000)
        else $error("read data not zero when idle");
    chk_unimpl_zero: assert property (@(posedge clock) disable iff (!rstN)
        (reg_q & ~sscf_pkg::FIELD_MASK) == 32'h0000_0000)
        else $error("unimplemented bit set");
    chk_other_addr: assert property (@(posedge clock) disable iff (!rstN)
        (cfgReq.wrEn && !hit && !pwrWriteEn) |=> reg_q == $past(reg_q))
        else $error("write to other offset changed register");
    chk_field_write: assert property (@(posedge clock) disable iff (!rstN)
        (cfgReq.wrEn && hit && cfgReq.byteEn == 4'hf) |=> reg_q[24] == $past(cfgReq.wrData[24]))
        else $error("mode enable write lost");
    chk_irq_masked: assert property (@(posedge clock) disable iff (!rstN)
        !pwrWriteEn |=> !pwrMgmtIrq)
        else $error("management irq without enabled power write");
    chk_flag_no_spurious: assert property (@(posedge clock) disable iff (!rstN)
        (!reg_q[25] && !pwrWriteEn) |=> !reg_q[25])
        else $error("flag set without enabled power write");
    chk_route_legacy: assert property (@(posedge clock) disable iff (!rstN)
        (pwrMgmtIrq && !reg_q[26]) |-> legacyIrqLineTwo)
        else $error("legacy line not raised");
    chk_rev_decode: assert property (@(posedge clock) disable iff (!rstN)
        ctrl.pmRev11 == reg_q[23])
        else $error("revision select decode wrong");
    chk_protect_decode: assert property (@(posedge clock) disable iff (!rstN)
        ctrl.supplyProtectOn == !reg_q[21])
        else $error("supply protection decode wrong");
    chk_burst_decode: assert property (@(posedge clock) disable iff (!rstN)
        ctrl.burstDownAllowed == reg_q[15])
        else $error("burst enable decode wrong");
    chk_dma_unused: assert property (@(posedge clock) disable iff (!rstN)
        ctrl.dmaUnused == (ctrl.dmaChannel == 3'h4))
        else $error("unused channel decode wrong");
    chk_dma_width8: assert property (@(posedge clock) disable iff (!rstN)
        (ctrl.dmaChannel < 3'h4) |-> !ctrl.dmaChannel16)
        else $error("eight-bit channel flagged wide");
    chk_dma_pass: assert property (@(posedge clock) disable iff (!rstN)
        (reg_q[19] && cardDmaRequest) |-> cardDmaReqOut)
        else $error("enabled dma request dropped");
    chk_rsvd_low: assert property (@(posedge clock) disable iff (!rstN)
        rsvdTermOut == 4'h0)
        else $error("reserved terminal driven high");
    chk_rsvd_float: assert property (@(posedge clock) disable iff (!rstN)
        !cardBusInserted |-> rsvdTermOe == 4'h0)
        else $error("reserved terminal driven without card");
    chk_float_off: assert property (@(posedge clock) disable iff (!rstN)
        !reg_q[20] |-> !addrHighFloat)
        else $error("address pins floated while disabled");
endmodule : sscf_socket_system_control_fields
